// ===== core/phe_pkg.sv
// constants and types for the header, pilot and precoder symbol generator
package phe_pkg;
  // header protection and coding
  localparam int HDR_BITS       = 720;
  localparam int CRC_DATA_BITS  = 704;
  localparam int CRC_W          = 16;
  localparam int PAR_W          = 176;
  localparam int CW_BITS        = 896;
  localparam int BCH_ZERO_PAD   = 1151;  // leading zeros, no effect on state
  localparam int BCH_SHIFT_BITS = 1871;
  localparam logic [CRC_W-1:0] CRC_POLY = 16'h3d65;
  localparam logic [191:0] BCH_GEN_FULL =
    192'h0001_a3e8_171d_bca4_ee1e_7cdc_a7da_fb8d_8f39_8072_8516_6007;
  localparam logic [PAR_W-1:0] BCH_GEN = BCH_GEN_FULL[PAR_W-1:0];

  // lfsr 1+x^22+x^25, stage 0 is the leftmost bit of the vector
  typedef logic [0:24] phe_lfsr_t;
  localparam phe_lfsr_t HDR_SCR_SEED = 25'h068d332;
  localparam phe_lfsr_t PILOT_SEED   = 25'h0ac2b4b;
  localparam int LFSR_TAP_A = 21;
  localparam int LFSR_TAP_B = 24;

  // sub-block layout
  localparam int ZERO_LEN        = 16;
  localparam int BODY_LEN        = 128;
  localparam int BLK_LEN         = 160;
  localparam int HDR_SUBFRAMES   = 14;
  localparam int TRAIN_SUBBLOCKS = 13;
  localparam int TRAIN_SYM_BITS  = 8;

  // power scaling
  localparam int SF_HDR   = 255;
  localparam int SF_SYNC  = 255;
  localparam int SF_TRAIN = 1;
  localparam int SF_THP_ON  [1:6] = '{128, 64, 32, 16, 8, 4};
  localparam int SF_THP_OFF [1:6] = '{255, 85, 36, 17, 8, 4};

  // precoder
  localparam int COEF_N    = 9;
  localparam int COEF_W    = 12;
  localparam int COEF_FRAC = 10;
  localparam int HIST_W    = 8;
  localparam int SYM_W     = 12;

  typedef enum logic [1:0] {
    KIND_SYNC  = 2'h0,
    KIND_TRAIN = 2'h1,
    KIND_HDR   = 2'h2
  } phe_kind_t;

  typedef enum logic {
    ST_IDLE  = 1'b0,
    ST_BLOCK = 1'b1
  } phe_state_t;
endpackage : phe_pkg

// ===== core/phe_top.sv
// transmit symbol generator: header crc/scramble/bch, pilots, scaling, thp
//
// Functional notes
// - crc16 over first 704 header bits, feedback on, given polynomial
// - crc stages cleared to zero at each frame start
// - then feedback off, crc shifted out s15 first as last 16 bits
// - header block xored with 1+x^22+x^25 lfsr output
// - header scrambler loaded with 0x0068_d332 each frame, left digit stage 0
// - scrambled header bch (896,720) encoded, given generator polynomial
// - bch stages cleared, 1151 zeros prepended, 1871 bits shifted with feedback
// - parity then output with feedback off, highest stage first
// - 896 coded bits mapped onto 1792 two-level symbols
// - 14 header subframes of 128 symbols, 16 zeros before and after
// - sync pilot: 128 symbols of +-1 from lfsr seeded 0x00ac_2b4b per frame
// - sync pilot bracketed by 16 zero symbols each side
// - training pilot 1664 symbols, 256 levels, 13 sub-blocks, same lfsr seed
// - training bits grouped by eight, last bit of group is msb
// - each training sub-block bracketed by 16 zero symbols
// - payload scaled by table factor chosen by pam order and precoding
// - header and sync symbols scaled by 255, training by 1
// - requested coefficient i drives feedback tap i
// - precoder history cleared before payload following any pilot/header
// - y = mod(x - v + m, 2m) - m, m = 2^floor(bits per dimension)
// - coefficients zero from reset until a request loads them
`timescale 1ns/1ps
module phe_top #(
  parameter int X_W = 8
) (
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire logic                        frame_start,
  input  wire logic [703:0]                physical_header_data,
  input  wire logic                        blk_start,
  input  wire logic [1:0]                  blk_kind,
  input  wire logic                        pay_valid,
  input  wire logic signed [X_W-1:0]       pay_sym,
  input  wire logic [3:0]                  bpd_code,
  input  wire logic                        coef_load,
  input  wire logic [107:0]                requested_precoder_coefficients,
  output logic                             sym_valid,
  output logic signed [phe_pkg::SYM_W-1:0] sym_out,
  output logic                             blk_busy,
  output logic                             hdr_ready
);

  // header encoder state
  logic [703:0]                  phd_r,     phd_nxt;
  logic [phe_pkg::CRC_W-1:0]     crc_r,     crc_nxt;
  logic [phe_pkg::PAR_W-1:0]     par_r,     par_nxt;
  logic [phe_pkg::CW_BITS-1:0]   cw_r,      cw_nxt;
  phe_pkg::phe_lfsr_t            scr_r,     scr_nxt;
  logic [9:0]                    enc_cnt_r, enc_cnt_nxt;
  logic                          enc_on_r,  enc_on_nxt;
  logic                          rdy_r,     rdy_nxt;
  logic                          enc_bit, scr_bit, enc_s, par_fb;

  // one bit per cycle through crc, scrambler and parity register
  always_comb begin
    phd_nxt     = phd_r;
    crc_nxt     = crc_r;
    par_nxt     = par_r;
    cw_nxt      = cw_r;
    scr_nxt     = scr_r;
    enc_cnt_nxt = enc_cnt_r;
    enc_on_nxt  = enc_on_r;
    rdy_nxt     = rdy_r;
    scr_bit = scr_r[phe_pkg::LFSR_TAP_A] ^ scr_r[phe_pkg::LFSR_TAP_B];
    enc_bit = 1'b0;
    enc_s   = 1'b0;
    par_fb  = 1'b0;
    if (frame_start) begin
      phd_nxt     = physical_header_data;
      crc_nxt     = '0;
      par_nxt     = '0;
      scr_nxt     = phe_pkg::HDR_SCR_SEED;
      enc_cnt_nxt = '0;
      enc_on_nxt  = 1'b1;
      rdy_nxt     = 1'b0;
    end else if (enc_on_r) begin
      if (enc_cnt_r < 10'(phe_pkg::CRC_DATA_BITS)) begin
        enc_bit = phd_r[enc_cnt_r];
        crc_nxt = {crc_r[14:0], 1'b0} ^
                  ((enc_bit ^ crc_r[15]) ? phe_pkg::CRC_POLY : '0);
      end else begin
        enc_bit = crc_r[15];
        crc_nxt = {crc_r[14:0], 1'b0};
      end
      enc_s   = enc_bit ^ scr_bit;
      scr_nxt = {scr_bit, scr_r[0:23]};
      // the 1151 prepended zeros leave an all-zero register unchanged, so
      // they cost no cycles here
      par_fb  = enc_s ^ par_r[phe_pkg::PAR_W-1];
      par_nxt = {par_r[phe_pkg::PAR_W-2:0], 1'b0} ^
                (par_fb ? phe_pkg::BCH_GEN : '0);
      cw_nxt[enc_cnt_r] = enc_s;
      enc_cnt_nxt = enc_cnt_r + 10'h001;
      if (enc_cnt_r == 10'(phe_pkg::HDR_BITS - 1)) begin
        // parity appended highest stage first
        for (int j = 0; j < phe_pkg::PAR_W; j++) begin
          cw_nxt[phe_pkg::HDR_BITS + j] =
            par_nxt[phe_pkg::PAR_W - 1 - j];
        end
        enc_on_nxt = 1'b0;
        rdy_nxt    = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      phd_r     <= '0;
      crc_r     <= '0;
      par_r     <= '0;
      cw_r      <= '0;
      scr_r     <= phe_pkg::HDR_SCR_SEED;
      enc_cnt_r <= '0;
      enc_on_r  <= 1'b0;
      rdy_r     <= 1'b0;
    end else begin
      phd_r     <= phd_nxt;
      crc_r     <= crc_nxt;
      par_r     <= par_nxt;
      cw_r      <= cw_nxt;
      scr_r     <= scr_nxt;
      enc_cnt_r <= enc_cnt_nxt;
      enc_on_r  <= enc_on_nxt;
      rdy_r     <= rdy_nxt;
    end
  end

  // precoder coefficients, tap i from slice i
  logic signed [phe_pkg::COEF_W-1:0] coef_r   [phe_pkg::COEF_N];
  logic signed [phe_pkg::COEF_W-1:0] coef_nxt [phe_pkg::COEF_N];
  logic                              thp_on;

  always_comb begin
    thp_on = 1'b0;
    for (int i = 0; i < phe_pkg::COEF_N; i++) begin
      coef_nxt[i] = coef_load ?
        requested_precoder_coefficients[i*phe_pkg::COEF_W +: phe_pkg::COEF_W]
        : coef_r[i];
      thp_on = thp_on | (|coef_r[i]);
    end
  end

  always_ff @(posedge clock) begin
    for (int i = 0; i < phe_pkg::COEF_N; i++) begin
      if (rst) begin
        coef_r[i] <= '0;
      end else begin
        coef_r[i] <= coef_nxt[i];
      end
    end
  end

  // block sequencer, pilots, precoder and output stage
  phe_pkg::phe_state_t               st_r,   st_nxt;
  phe_pkg::phe_kind_t                kind_r, kind_nxt;
  logic [7:0]                        pos_r,  pos_nxt;
  logic [3:0]                        hsf_r,  hsf_nxt;
  logic [3:0]                        tsb_r,  tsb_nxt;
  phe_pkg::phe_lfsr_t                sp_r,   sp_nxt;
  phe_pkg::phe_lfsr_t                tp_r,   tp_nxt;
  logic signed [phe_pkg::HIST_W-1:0] hist_r   [phe_pkg::COEF_N];
  logic signed [phe_pkg::HIST_W-1:0] hist_nxt [phe_pkg::COEF_N];
  logic                              vld_r,  vld_nxt;
  logic signed [phe_pkg::SYM_W-1:0]  out_r,  out_nxt;
  logic                              busy_r, busy_nxt;
  logic                              allow, in_body, lbit;
  logic [7:0]                        tsym;
  logic [9:0]                        cw_idx;
  logic [2:0]                        kfl;
  logic signed [23:0]                v_acc;
  logic signed [15:0]                v_int, u, y, m, sf, scaled;
  logic [15:0]                       wrapped;

  always_comb begin
    st_nxt   = st_r;
    kind_nxt = kind_r;
    pos_nxt  = pos_r;
    hsf_nxt  = hsf_r;
    tsb_nxt  = tsb_r;
    sp_nxt   = sp_r;
    tp_nxt   = tp_r;
    hist_nxt = hist_r;
    vld_nxt  = 1'b0;
    out_nxt  = '0;
    lbit     = 1'b0;
    tsym     = '0;
    cw_idx   = '0;
    in_body  = (pos_r >= 8'(phe_pkg::ZERO_LEN)) &&
               (pos_r < 8'(phe_pkg::ZERO_LEN + phe_pkg::BODY_LEN));
    allow    = (blk_kind == phe_pkg::KIND_SYNC) ||
               (blk_kind == phe_pkg::KIND_TRAIN &&
                tsb_r < 4'(phe_pkg::TRAIN_SUBBLOCKS)) ||
               (blk_kind == phe_pkg::KIND_HDR && rdy_r &&
                hsf_r < 4'(phe_pkg::HDR_SUBFRAMES));
    // payload modulus and scale from the coding configuration
    // reserved code fifteen would wrap the 3-bit floor, so pin all codes above eleven to six
    kfl = (bpd_code > 4'hb) ? 3'h6 :
          3'(({1'b0, bpd_code} + 5'h01) >> 1);
    if (kfl < 3'h1) kfl = 3'h1;
    if (kfl > 3'h6) kfl = 3'h6;
    m  = 16'sh0001 <<< kfl;
    sf = 16'(thp_on ? phe_pkg::SF_THP_ON[kfl]
                    : phe_pkg::SF_THP_OFF[kfl]);
    v_acc = '0;
    for (int i = 0; i < phe_pkg::COEF_N; i++) begin
      v_acc = v_acc + 24'(coef_r[i]) * 24'(hist_r[i]);
    end
    // rounding v to an integer keeps the history narrow; the loss is
    // at most half a level
    v_int   = 16'((v_acc + 24'sh000200) >>> phe_pkg::COEF_FRAC);
    u       = 16'(pay_sym) - v_int;
    wrapped = 16'(u + m) & 16'(2*m - 16'sh0001);
    y       = $signed(wrapped) - m;
    scaled  = 16'(y * sf);
    if (frame_start) begin
      sp_nxt  = phe_pkg::PILOT_SEED;
      tp_nxt  = phe_pkg::PILOT_SEED;
      hsf_nxt = '0;
      tsb_nxt = '0;
    end
    unique case (st_r)
      phe_pkg::ST_IDLE: begin
        if (blk_start && allow) begin
          st_nxt   = phe_pkg::ST_BLOCK;
          kind_nxt = phe_pkg::phe_kind_t'(blk_kind);
          pos_nxt  = '0;
        end else if (pay_valid) begin
          vld_nxt  = 1'b1;
          out_nxt  = scaled[phe_pkg::SYM_W-1:0];
          hist_nxt[0] = y[phe_pkg::HIST_W-1:0];
          for (int i = 1; i < phe_pkg::COEF_N; i++) begin
            hist_nxt[i] = hist_r[i-1];
          end
        end
      end
      phe_pkg::ST_BLOCK: begin
        vld_nxt = 1'b1;
        // any non-payload block wipes the feedback history
        for (int i = 0; i < phe_pkg::COEF_N; i++) begin
          hist_nxt[i] = '0;
        end
        // zero symbols outside the body
        if (in_body) begin
          unique case (kind_r)
            phe_pkg::KIND_SYNC: begin
              lbit    = sp_r[phe_pkg::LFSR_TAP_A] ^ sp_r[phe_pkg::LFSR_TAP_B];
              sp_nxt  = {lbit, sp_r[0:23]};
              out_nxt = lbit ? -12'(phe_pkg::SF_SYNC)
                             : 12'(phe_pkg::SF_SYNC);
            end
            phe_pkg::KIND_TRAIN: begin
              // eight lfsr steps per symbol, first bit lands in the lsb
              for (int k = 0; k < phe_pkg::TRAIN_SYM_BITS; k++) begin
                lbit    = tp_nxt[phe_pkg::LFSR_TAP_A] ^
                          tp_nxt[phe_pkg::LFSR_TAP_B];
                tsym[k] = lbit;
                tp_nxt  = {lbit, tp_nxt[0:23]};
              end
              out_nxt = 12'(phe_pkg::SF_TRAIN) *
                        ($signed({3'h0, tsym, 1'b0}) - 12'sh0ff);
            end
            phe_pkg::KIND_HDR: begin
              // two symbols per coded bit
              cw_idx  = 10'({hsf_r, 6'h00}) +
                        10'((pos_r - 8'(phe_pkg::ZERO_LEN)) >> 1);
              lbit    = cw_r[cw_idx];
              out_nxt = lbit ? -12'(phe_pkg::SF_HDR)
                             : 12'(phe_pkg::SF_HDR);
            end
            default: out_nxt = '0;
          endcase
        end
        pos_nxt = pos_r + 8'h01;
        if (pos_r == 8'(phe_pkg::BLK_LEN - 1)) begin
          st_nxt = phe_pkg::ST_IDLE;
          if (kind_r == phe_pkg::KIND_HDR)   hsf_nxt = hsf_nxt + 4'h1;
          if (kind_r == phe_pkg::KIND_TRAIN) tsb_nxt = tsb_nxt + 4'h1;
        end
      end
    endcase
    busy_nxt = (st_nxt == phe_pkg::ST_BLOCK);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r   <= phe_pkg::ST_IDLE;
      kind_r <= phe_pkg::KIND_SYNC;
      pos_r  <= '0;
      hsf_r  <= '0;
      tsb_r  <= '0;
      sp_r   <= phe_pkg::PILOT_SEED;
      tp_r   <= phe_pkg::PILOT_SEED;
      vld_r  <= 1'b0;
      out_r  <= '0;
      busy_r <= 1'b0;
      for (int i = 0; i < phe_pkg::COEF_N; i++) hist_r[i] <= '0;
    end else begin
      st_r   <= st_nxt;
      kind_r <= kind_nxt;
      pos_r  <= pos_nxt;
      hsf_r  <= hsf_nxt;
      tsb_r  <= tsb_nxt;
      sp_r   <= sp_nxt;
      tp_r   <= tp_nxt;
      vld_r  <= vld_nxt;
      out_r  <= out_nxt;
      busy_r <= busy_nxt;
      for (int i = 0; i < phe_pkg::COEF_N; i++) hist_r[i] <= hist_nxt[i];
    end
  end

  // every output straight from a flop
  assign sym_valid = vld_r;
  assign sym_out   = out_r;
  assign blk_busy  = busy_r;
  assign hdr_ready = rdy_r;

endmodule : phe_top

// ===== dv/phe_checker.sv
// port assertions for the symbol generator
`timescale 1ns/1ps
module phe_checker (
  input wire logic                             clock,
  input wire logic                             rst,
  input wire logic                             frame_start,
  input wire logic                             blk_start,
  input wire logic                             pay_valid,
  input wire logic                             sym_valid,
  input wire logic signed [phe_pkg::SYM_W-1:0] sym_out,
  input wire logic                             blk_busy,
  input wire logic                             hdr_ready
);
  logic [10:0] fs_cnt_r;
  logic [10:0] fs_cnt_nxt;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // cycles since frame start; saturates so a stale count never wraps
  always_comb begin
    fs_cnt_nxt = fs_cnt_r;
    if (rst)
      fs_cnt_nxt = 11'h7ff;
    else if (frame_start)
      fs_cnt_nxt = 11'h001;
    else if (fs_cnt_r != 11'h7ff)
      fs_cnt_nxt = fs_cnt_r + 11'h001;
  end

  always_ff @(posedge clock) begin
    fs_cnt_r <= fs_cnt_nxt;
  end

  a_rst_clears: assert property (disable iff (1'b0)
    rst |=> !sym_valid && !blk_busy && !hdr_ready && sym_out == '0)
    else $error("outputs not cleared by reset");
  a_lead_zeros: assert property ($rose(blk_busy) |->
    ##1 (sym_valid && sym_out == '0)[*8] ##1 (sym_valid && sym_out == '0)[*8])
    else $error("leading guard not sixteen zeros");
  a_body_nonzero: assert property ($rose(blk_busy) |->
    ##17 (sym_valid && sym_out != '0)[*8])
    else $error("block body starts with a zero symbol");
  a_trail_zeros: assert property ($rose(blk_busy) |->
    ##145 (sym_valid && sym_out == '0)[*8] ##1 (sym_out == '0)[*8])
    else $error("trailing guard not sixteen zeros");
  a_busy_hold: assert property ($rose(blk_busy) |-> blk_busy[*8])
    else $error("busy dropped early");
  a_hdr_timing: assert property ($rose(hdr_ready) |->
    fs_cnt_r == 11'h2d1)
    else $error("codeword ready at wrong time");
  a_pay_latency: assert property (pay_valid && !blk_busy && !blk_start
    && !sym_valid |=> sym_valid)
    else $error("payload symbol not issued");
  a_sym_cause: assert property (sym_valid |->
    $past(pay_valid) || $past(blk_busy))
    else $error("symbol without cause");
  a_sym_range: assert property (sym_valid |->
    sym_out >= -256 && sym_out <= 255)
    else $error("symbol out of scaled range");
endmodule : phe_checker

bind phe_top phe_checker u_chk (
  .clock(clock), .rst(rst), .frame_start(frame_start),
  .blk_start(blk_start), .pay_valid(pay_valid), .sym_valid(sym_valid),
  .sym_out(sym_out), .blk_busy(blk_busy), .hdr_ready(hdr_ready)
);

// ===== dv/phe_eo_sink.sv
// behavioural sink standing in for the electro-optical transmitter
`timescale 1ns/1ps
module phe_eo_sink (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        sym_valid,
  output logic      [15:0] sym_count
);
  // counts every launched symbol, guard zeros included
  always_ff @(posedge clock) begin
    if (rst)
      sym_count <= 16'h0000;
    else if (sym_valid)
      sym_count <= sym_count + 16'h0001;
  end
endmodule : phe_eo_sink

// ===== dv/tb_top.sv
// self-checking bench for the header, pilot and precoder symbol generator
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %0d exp %0d", $time, g, e); end end
module tb_top;
  typedef struct {logic [3:0] bpd; logic [7:0] x; logic [11:0] y;} phe_row_t;
  logic                             clock, rst, frame_start, blk_start;
  logic                             pay_valid, coef_load, sym_valid;
  logic                             blk_busy, hdr_ready;
  logic [1:0]                       blk_kind;
  logic [3:0]                       bpd_code;
  logic signed [7:0]                pay_sym;
  logic [703:0]                     hdr_bits;
  logic [107:0]                     coefs;
  logic signed [phe_pkg::SYM_W-1:0] sym_out;
  logic [15:0]                      sink_count;
  logic [11:0]                      exp_sym [0:159];
  logic                             cw [0:895];
  phe_pkg::phe_lfsr_t               s_tr;
  int                               fail_count, checked, cyc, n;
  // precoding off: bpd code, level, scaled symbol
  phe_row_t rows [0:7] = '{'{4'h1, 8'h01, 12'h0ff}, '{4'h1, 8'hff, 12'hf01},
    '{4'h0, 8'h01, 12'h0ff}, '{4'h3, 8'h03, 12'h0ff}, '{4'h5, 8'hf9, 12'hf04},
    '{4'h7, 8'h0f, 12'h0ff}, '{4'h9, 8'he1, 12'hf08}, '{4'hb, 8'h3f, 12'h0fc}};

  phe_top u_dut (.clock(clock), .rst(rst), .frame_start(frame_start),
    .physical_header_data(hdr_bits), .blk_start(blk_start),
    .blk_kind(blk_kind), .pay_valid(pay_valid), .pay_sym(pay_sym),
    .bpd_code(bpd_code), .coef_load(coef_load),
    .requested_precoder_coefficients(coefs), .sym_valid(sym_valid),
    .sym_out(sym_out), .blk_busy(blk_busy), .hdr_ready(hdr_ready));
  phe_eo_sink u_sink (.clock(clock), .rst(rst), .sym_valid(sym_valid),
    .sym_count(sink_count));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // x^22 and x^25 taps; new bit enters stage 0
  function automatic logic lfsr_step(inout phe_pkg::phe_lfsr_t s);
    logic b;
    b = s[21] ^ s[24];
    s = {b, s[0:23]};
    return b;
  endfunction : lfsr_step

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  task automatic pulse(ref logic sig);
    sig = 1'b1;
    @(posedge clock);
    #1 sig = 1'b0;
  endtask : pulse

  task automatic run_rows();
    foreach (rows[i]) begin
      bpd_code = rows[i].bpd;
      pay_sym = rows[i].x;
      pay_valid = 1'b1;
      @(posedge clock);
      #1 `CHK(sym_out, rows[i].y)
    end
    pay_valid = 1'b0;
  endtask : run_rows

  // bpd 1, level +1; pattern bit set means y = +1 scaled by 128
  task automatic pay_run(input int cnt, input logic [7:0] pat);
    bpd_code = 4'h1;
    pay_sym = 8'h01;
    pay_valid = 1'b1;
    for (int i = 0; i < cnt; i++) begin
      @(posedge clock);
      #1 `CHK(sym_out, pat[i] ? 12'h080 : 12'h000)
    end
    pay_valid = 1'b0;
  endtask : pay_run

  task automatic run_blk(input logic [1:0] kind);
    logic [15:0] n0;
    int w;
    n0 = sink_count;
    blk_kind = kind;
    pulse(blk_start);
    w = 0;
    while (sym_valid !== 1'b1 && w < 4) begin
      @(posedge clock);
      #1 w++;
    end
    `CHK(w, 1)
    for (int i = 0; i < 160; i++) begin
      `CHK(sym_out, exp_sym[i])
      @(posedge clock);
      #1;
    end
    `CHK(sym_valid, 1'b0)
    `CHK(sink_count, n0 + 16'h00a0)
  endtask : run_blk

  // a full frame allowance already used, so the request must be ignored
  task automatic refused(input logic [1:0] kind);
    blk_kind = kind;
    pulse(blk_start);
    repeat (3) @(posedge clock);
    #1 `CHK(blk_busy, 1'b0)
  endtask : refused

  task automatic fill_sync();
    phe_pkg::phe_lfsr_t s;
    s = phe_pkg::PILOT_SEED;
    exp_sym = '{default: 12'h000};
    for (int i = 0; i < 128; i++)
      exp_sym[16+i] = lfsr_step(s) ? 12'hf01 : 12'h0ff;
  endtask : fill_sync

  // training sub-blocks continue one lfsr through the frame
  task automatic fill_train();
    logic [7:0] v;
    exp_sym = '{default: 12'h000};
    for (int i = 0; i < 128; i++) begin
      for (int b = 0; b < 8; b++)
        v[b] = lfsr_step(s_tr);
      exp_sym[16+i] = {3'h0, v, 1'b0} - 12'h0ff;
    end
  endtask : fill_train

  // crc, scrambler and systematic parity of the whole codeword
  task automatic build_cw();
    logic [15:0] c;
    logic [175:0] p;
    phe_pkg::phe_lfsr_t s;
    logic fb;
    logic hb;
    c = '0;
    p = '0;
    s = phe_pkg::HDR_SCR_SEED;
    for (int i = 0; i < 720; i++) begin
      hb = (i < 704) ? hdr_bits[i] : c[15];
      fb = hdr_bits[i % 704] ^ c[15];
      if (i < 704)
        c = {c[14:0], 1'b0} ^ (fb ? phe_pkg::CRC_POLY : 16'h0000);
      else
        c = {c[14:0], 1'b0};
      cw[i] = hb ^ lfsr_step(s);
      fb = cw[i] ^ p[175];
      p = {p[174:0], 1'b0} ^ (fb ? phe_pkg::BCH_GEN : 176'h0);
    end
    for (int i = 0; i < 176; i++)
      cw[720+i] = p[175-i];
  endtask : build_cw

  always @(posedge clock) begin
    cyc++;
    if (cyc == 10000) begin
      fail_count++;
      close_out();
    end
  end

  initial begin
    {rst, frame_start, blk_start, pay_valid, coef_load} = 5'h10;
    blk_kind = 2'h0;
    bpd_code = 4'h1;
    pay_sym = 8'h01;
    coefs = '0;
    hdr_bits = {22{32'hc3a5_1e69}};
    repeat (12) @(posedge clock);
    #1 rst = 1'b0;
    `CHK(sym_valid, 1'b0)
    run_rows();
    pulse(frame_start);
    n = 0;
    while (hdr_ready !== 1'b1 && n < 800) begin
      @(posedge clock);
      #1 n++;
    end
    `CHK(n, 720)
    build_cw();
    fill_sync();
    run_blk(phe_pkg::KIND_SYNC);
    s_tr = phe_pkg::PILOT_SEED;
    for (int j = 0; j < 13; j++) begin
      fill_train();
      run_blk(phe_pkg::KIND_TRAIN);
    end
    refused(phe_pkg::KIND_TRAIN);
    for (int k = 0; k < 14; k++) begin
      exp_sym = '{default: 12'h000};
      for (int b = 0; b < 128; b++)
        exp_sym[16+b] = cw[64*k+b/2] ? 12'hf01 : 12'h0ff;
      run_blk(phe_pkg::KIND_HDR);
    end
    refused(phe_pkg::KIND_HDR);
    coefs = 108'h400000;  // tap 1 at +1.0, others zero
    pulse(coef_load);
    pay_run(5, 8'h13);
    pulse(frame_start);
    fill_sync();
    run_blk(phe_pkg::KIND_SYNC);
    pay_run(2, 8'h03);
    rst = 1'b1;
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    `CHK(blk_busy, 1'b0)
    run_rows();
    close_out();
  end
endmodule : tb_top
